// *** design/gsba_pkg.sv ***
/*
  Shared constants, types and helpers of the gigabit serdes byte aligner.
  Assumes one 50 MHz system clock; every pin is sampled on that clock.
*/

package gsba_pkg;

  localparam int          WORD_W          = 10;
  localparam int          COMMA_W         = 7;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          TX_BITS_PER_REF = 10;
  localparam int          BIT_SYNC_BITS   = 2500;
  localparam int          FREQ_LOCK_EDGES = 4;
  localparam int          REF_LOSS_CYCLES = 64;
  localparam int          LOCK_CNT_W      = 12;
  localparam int          GAP_CNT_W       = 8;

  localparam logic [COMMA_W-1:0] COMMA_PATTERN = 7'h7C;
  localparam logic [WORD_W-1:0]  RX_NO_SIGNAL  = 10'h3FF;
  localparam logic [3:0]         BIT_FIRST     = 4'h0;
  localparam logic [3:0]         BIT_LAST      = 4'h9;
  localparam logic               LINE_IDLE     = 1'h1;
  localparam logic               LOOP_PIN_LVL  = 1'h1;

  typedef enum {
    GSBA_LK_FREQ,
    GSBA_LK_PHASE,
    GSBA_LK_LOCKED
  } gsba_lock_t;

  typedef struct packed {
    logic              comma;
    logic [WORD_W-1:0] bits;
  } gsba_rx_word_t;

  // Receive order: bit 0 is oldest, so the pattern sits in the low bits
  function automatic logic gsba_is_comma(input logic [WORD_W-1:0] w);
    return w[COMMA_W-1:0] == COMMA_PATTERN;
  endfunction

endpackage

// *** design/gsba_word_fifo.sv ***
/*
  Word FIFO with valid/ready on both sides, parameterised width and depth.
  Assumes DEPTH is a power of two and a single clock domain.
*/
module gsba_word_fifo
  import gsba_pkg::*;
#(
  parameter int W     = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_ff;
  logic [AW:0]  rd_ptr_ff;

  wire          ptr_wrap = wr_ptr_ff[AW] != rd_ptr_ff[AW];
  wire          ptr_same = wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0];
  wire          full     = ptr_wrap & ptr_same;
  wire          empty    = ~ptr_wrap & ptr_same;
  wire          push     = in_valid & ~full;
  wire          pop      = out_ready & ~empty;

  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Storage, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

endmodule // gsba_word_fifo

// *** design/gsba_aligner.sv ***
/*
  Serdes byte aligner: transmit capture, FIFO and serializer, loopback,
  lock sequencing, deserializer with comma alignment, byte clocks and
  signal-loss forcing.
  Assumes all pins, the reference clock included, are asynchronous to
  sys_clk and are sampled through two flip-flops; one serial bit is one
  sys_clk cycle.
*/
module gsba_aligner
  import gsba_pkg::*;
#(
  parameter int              DEPTH_P      = FIFO_DEPTH,
  parameter logic [LOCK_CNT_W-1:0] BIT_SYNC_P = LOCK_CNT_W'(BIT_SYNC_BITS),
  parameter logic [LOCK_CNT_W-1:0] FREQ_EDGES_P = LOCK_CNT_W'(FREQ_LOCK_EDGES),
  parameter logic [GAP_CNT_W-1:0]  REF_LOSS_P = GAP_CNT_W'(REF_LOSS_CYCLES)
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              ref_byte_clock,
  input  wire logic [WORD_W-1:0] tx_word,
  input  wire logic              loopback_select,
  input  wire logic              sync_enable,
  input  wire logic              serial_in,
  input  wire logic              amplitude_ok,
  output logic                   serial_out,
  output logic                   tx_ready,
  output logic [WORD_W-1:0]      rx_word,
  output logic                   rx_comma_flag,
  output logic                   rx_byte_clock_lead,
  output logic                   rx_byte_clock_trail,
  output logic                   input_present_flag,
  output logic                   rx_bit_locked
);

  localparam int PIN_W = WORD_W + 5;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [PIN_W-1:0]  sync1_ff;
  logic [PIN_W-1:0]  sync2_ff;
  logic              ref_prev_ff;

  wire [PIN_W-1:0]   pin_bus = {tx_word, ref_byte_clock, loopback_select,
                                sync_enable, serial_in, amplitude_ok};

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_bus;
      sync2_ff <= sync1_ff;
    end
  end

  wire [WORD_W-1:0]  tx_word_s = sync2_ff[PIN_W-1:5];
  wire               ref_s     = sync2_ff[4];
  wire               loop_s    = sync2_ff[3];
  wire               sync_en_s = sync2_ff[2];
  wire               ser_in_s  = sync2_ff[1];
  wire               amp_s     = sync2_ff[0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_prev_ff <= 1'h0;
    end else begin
      ref_prev_ff <= ref_s;
    end
  end

  wire               ref_rise = ref_s & ~ref_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit capture and buffering
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;

  // Words ride the FIFO so a late serializer does not lose them
  gsba_word_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH_P)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (ref_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (tx_word_s),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serializer
  logic [WORD_W-1:0] tx_shift_ff;
  logic [WORD_W-1:0] nxt_tx_shift;
  logic [3:0]        tx_cnt_ff;
  logic [3:0]        nxt_tx_cnt;
  logic              tx_busy_ff;
  logic              nxt_tx_busy;

  wire               tx_last = tx_busy_ff & (tx_cnt_ff == BIT_LAST);
  wire               tx_load = fifo_out_valid & (~tx_busy_ff | tx_last);

  assign fifo_out_ready = ~tx_busy_ff | tx_last;

  // Ten bit slots per word; shifting right sends bit zero first
  always_comb begin
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    nxt_tx_busy  = tx_busy_ff;
    if (tx_load) begin
      nxt_tx_shift = fifo_out_data;
      nxt_tx_cnt   = BIT_FIRST;
      nxt_tx_busy  = 1'h1;
    end else if (tx_busy_ff) begin
      nxt_tx_shift = {1'h0, tx_shift_ff[WORD_W-1:1]};
      nxt_tx_cnt   = tx_cnt_ff + 4'h1;
      nxt_tx_busy  = ~tx_last;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_shift_ff <= '0;
      tx_cnt_ff   <= BIT_FIRST;
      tx_busy_ff  <= 1'h0;
    end else begin
      tx_shift_ff <= nxt_tx_shift;
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_busy_ff  <= nxt_tx_busy;
    end
  end

  // Idle line sits high between words
  wire               tx_bit = tx_busy_ff ? tx_shift_ff[0] : LINE_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Output and input select
  logic              serial_out_ff;
  logic              tx_ready_ff;

  wire               nxt_serial_out = loop_s ? LOOP_PIN_LVL : tx_bit;
  wire               rx_sel_bit     = loop_s ? tx_bit : ser_in_s;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_ff <= LINE_IDLE;
      tx_ready_ff   <= 1'h0;
    end else begin
      serial_out_ff <= nxt_serial_out;
      tx_ready_ff   <= fifo_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock sequencing
  gsba_lock_t              lock_ff;
  gsba_lock_t              nxt_lock;
  logic [LOCK_CNT_W-1:0]   lock_cnt_ff;
  logic [LOCK_CNT_W-1:0]   nxt_lock_cnt;
  logic [GAP_CNT_W-1:0]    ref_gap_ff;

  // A stalled reference drops the receiver back to frequency lock
  wire               ref_lost = ref_gap_ff == REF_LOSS_P;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_gap_ff <= '0;
    end else if (ref_rise) begin
      ref_gap_ff <= '0;
    end else if (!ref_lost) begin
      ref_gap_ff <= ref_gap_ff + 1'b1;
    end
  end

  always_comb begin
    nxt_lock     = lock_ff;
    nxt_lock_cnt = lock_cnt_ff;
    case (lock_ff)
      GSBA_LK_FREQ: begin
        if (ref_rise) begin
          nxt_lock_cnt = lock_cnt_ff + 1'b1;
        end
        if (lock_cnt_ff == FREQ_EDGES_P) begin
          nxt_lock     = GSBA_LK_PHASE;
          nxt_lock_cnt = '0;
        end
      end
      GSBA_LK_PHASE: begin
        if (!amp_s) begin
          nxt_lock_cnt = '0;
        end else if (lock_cnt_ff == BIT_SYNC_P) begin
          nxt_lock     = GSBA_LK_LOCKED;
          nxt_lock_cnt = '0;
        end else begin
          nxt_lock_cnt = lock_cnt_ff + 1'b1;
        end
      end
      GSBA_LK_LOCKED: begin
        if (!amp_s) begin
          nxt_lock = GSBA_LK_PHASE;
        end
      end
      default: begin
        nxt_lock     = GSBA_LK_FREQ;
        nxt_lock_cnt = '0;
      end
    endcase
    if (ref_lost) begin
      nxt_lock     = GSBA_LK_FREQ;
      nxt_lock_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lock_ff     <= GSBA_LK_FREQ;
      lock_cnt_ff <= '0;
    end else begin
      lock_ff     <= nxt_lock;
      lock_cnt_ff <= nxt_lock_cnt;
    end
  end

  wire               locked = lock_ff == GSBA_LK_LOCKED;

  ////////////////////////////////////////////////////////////////////////////
  // Deserializer and comma alignment
  logic [WORD_W-1:0] rx_shift_ff;
  logic [3:0]        rx_cnt_ff;
  logic [3:0]        nxt_rx_cnt;

  // Newest bit enters at the top so the first one ends at bit zero
  wire [WORD_W-1:0]  nxt_window = {rx_sel_bit, rx_shift_ff[WORD_W-1:1]};
  wire               rx_slot_end = rx_cnt_ff == BIT_LAST;
  // Comma ignored while sync is off, so the phase is kept
  wire               comma_hit = locked & sync_en_s & gsba_is_comma(nxt_window);
  // Misaligned comma: boundary moved later, the partial word dropped
  wire               realign   = comma_hit & ~rx_slot_end;
  wire               word_done = locked & rx_slot_end;

  always_comb begin
    nxt_rx_cnt = rx_cnt_ff;
    if (!locked || realign || word_done) begin
      nxt_rx_cnt = BIT_FIRST;
    end else begin
      nxt_rx_cnt = rx_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_shift_ff <= '0;
      rx_cnt_ff   <= BIT_FIRST;
    end else begin
      if (locked) begin
        rx_shift_ff <= nxt_window;
      end
      rx_cnt_ff <= nxt_rx_cnt;
    end
  end

  gsba_rx_word_t     rx_new;

  assign rx_new.comma = comma_hit & word_done;
  assign rx_new.bits  = nxt_window;

  ////////////////////////////////////////////////////////////////////////////
  // Byte clocks and receive outputs
  logic              lead_ff;
  logic              trail_ff;
  logic              lead_next_ff;
  logic [WORD_W-1:0] rx_word_ff;
  logic              rx_comma_ff;
  logic              present_ff;
  logic              locked_ff;
  logic              skip_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Realignment bookkeeping
  // A moved boundary sets the phase so the next comma rises on lead.
  // With trail high, the first word after the move leaves both clocks
  // still: trail is stretched, never cut into a runt.
  // Cost: that one word shows on rx_word without its own clock edge.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      skip_ff <= 1'h0;
    end else if (realign) begin
      skip_ff <= trail_ff;
    end else if (word_done) begin
      skip_ff <= 1'h0;
    end
  end

  // Byte clocks step only on words that are not held back
  wire               clk_step = word_done & ~skip_ff;

  // Detected comma words take the leading clock unless held back; a repeat holds it high longer
  wire               use_lead = lead_next_ff | rx_new.comma;
  wire [WORD_W-1:0]  nxt_rx_word = !amp_s ? RX_NO_SIGNAL :
                                   word_done ? rx_new.bits : rx_word_ff;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lead_ff      <= 1'h0;
      trail_ff     <= 1'h0;
      lead_next_ff <= 1'h1;
    end else if (clk_step) begin
      lead_ff      <= use_lead;
      trail_ff     <= ~use_lead;
      lead_next_ff <= ~use_lead;
    end else if (realign) begin
      // Lead high now: next word on trail, comma after it on lead
      lead_next_ff <= trail_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_word_ff  <= RX_NO_SIGNAL;
      rx_comma_ff <= 1'h0;
      present_ff  <= 1'h0;
      locked_ff   <= 1'h0;
    end else begin
      rx_word_ff  <= nxt_rx_word;
      if (word_done) begin
        rx_comma_ff <= rx_new.comma;
      end
      present_ff  <= amp_s;
      locked_ff   <= locked;
    end
  end

  assign serial_out          = serial_out_ff;
  assign tx_ready            = tx_ready_ff;
  assign rx_word             = rx_word_ff;
  assign rx_comma_flag       = rx_comma_ff;
  assign rx_byte_clock_lead  = lead_ff;
  assign rx_byte_clock_trail = trail_ff;
  assign input_present_flag  = present_ff;
  assign rx_bit_locked       = locked_ff;

endmodule // gsba_aligner

// *** testbench/gsba_aligner_properties.sv ***
/*
  Port checker of the byte aligner.
  Assumes binding to gsba_aligner and one sys_clk domain.
*/
module gsba_aligner_properties
  import gsba_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic              ref_byte_clock,
  input wire logic [WORD_W-1:0] tx_word,
  input wire logic              loopback_select,
  input wire logic              sync_enable,
  input wire logic              serial_in,
  input wire logic              amplitude_ok,
  input wire logic              serial_out,
  input wire logic              tx_ready,
  input wire logic [WORD_W-1:0] rx_word,
  input wire logic              rx_comma_flag,
  input wire logic              rx_byte_clock_lead,
  input wire logic              rx_byte_clock_trail,
  input wire logic              input_present_flag,
  input wire logic              rx_bit_locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Four edges cover the two-stage pin sync plus output register
  sequence s_weak;    !amplitude_ok[*4]; endsequence
  sequence s_strong;  amplitude_ok[*4]; endsequence
  sequence s_looped;  loopback_select[*4]; endsequence
  sequence s_lead_hi; rx_byte_clock_lead[*8]; endsequence
  sequence s_trl_hi;  rx_byte_clock_trail[*8]; endsequence

  AST_LOOP_HOLD: assert property (s_looped |-> serial_out == LOOP_PIN_LVL)
    else $error("serial out moved under loopback");
  AST_WEAK_FORCE: assert property (s_weak |-> rx_word == RX_NO_SIGNAL)
    else $error("receive word not forced under weak input");
  AST_WEAK_FLAG: assert property (s_weak |-> !input_present_flag)
    else $error("presence flag high under weak input");
  AST_PRESENT: assert property (s_strong |-> input_present_flag)
    else $error("presence flag low under valid input");
  AST_LEAD_ANTI: assert property ($rose(rx_byte_clock_lead) |-> !rx_byte_clock_trail)
    else $error("lead rose with trail high");
  AST_TRAIL_ANTI: assert property ($rose(rx_byte_clock_trail) |-> !rx_byte_clock_lead)
    else $error("trail rose with lead high");
  AST_LEAD_NO_RUNT: assert property ($rose(rx_byte_clock_lead) |=> s_lead_hi)
    else $error("short lead pulse");
  AST_TRAIL_NO_RUNT: assert property ($rose(rx_byte_clock_trail) |=> s_trl_hi)
    else $error("short trail pulse");
  AST_COMMA_ON_LEAD: assert property ($rose(rx_comma_flag) && input_present_flag
    |-> rx_byte_clock_lead && !rx_byte_clock_trail && rx_word[COMMA_W-1:0] == COMMA_PATTERN)
    else $error("comma word not on lead edge");
endmodule // gsba_aligner_properties

////////////////////////////////////////////////////////////////
bind gsba_aligner gsba_aligner_properties u_gsba_aligner_properties (
  .sys_clk(sys_clk), .rstn(rstn), .ref_byte_clock(ref_byte_clock), .tx_word(tx_word),
  .loopback_select(loopback_select), .sync_enable(sync_enable), .serial_in(serial_in),
  .amplitude_ok(amplitude_ok), .serial_out(serial_out), .tx_ready(tx_ready),
  .rx_word(rx_word), .rx_comma_flag(rx_comma_flag), .rx_byte_clock_lead(rx_byte_clock_lead),
  .rx_byte_clock_trail(rx_byte_clock_trail), .input_present_flag(input_present_flag),
  .rx_bit_locked(rx_bit_locked));

// *** testbench/gsba_mac_model.sv ***
/*
  Link controller model: reference byte clock and transmit words.
  Assumes tx_ready from the aligner; a halted clock stands still low.
*/
module gsba_mac_model
  import gsba_pkg::*;
(
  input  wire logic        tx_ready,
  input  wire logic        halt,
  output logic             ref_byte_clock,
  output logic [WORD_W-1:0] tx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [WORD_W-1:0] IDLE_WORD = 10'h2A5;
  logic [WORD_W-1:0] q[$];
  logic              rose;

  task automatic send(input logic [WORD_W-1:0] w);
    q.push_back(w);
  endtask

  // Skipping a rise while full keeps queued words from being dropped
  initial begin
    ref_byte_clock = 1'b0;
    tx_word        = IDLE_WORD;
    #7ns;
    forever begin
      #80ns;
      rose = tx_ready === 1'b1 && !halt;
      ref_byte_clock = rose;
      #80ns;
      ref_byte_clock = 1'b0;
      if (rose) tx_word = q.size() ? q.pop_front() : IDLE_WORD;
    end
  end
endmodule // gsba_mac_model

// *** testbench/gsba_aligner_bench.sv ***
/*
  Self-checking bench of the byte aligner.
  Assumes the bound checker and the link controller model.
*/
module gsba_aligner_bench;
  import gsba_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [WORD_W-1:0] COMMA_WORD = 10'h17C;
  localparam logic [WORD_W-1:0] DATA_A     = 10'h0D3;
  localparam logic [WORD_W-1:0] DATA_B     = 10'h31A;
  logic sys_clk = 1'b0, rstn = 1'b0, loopback_select = 1'b0, serial_in = 1'b0;
  logic amplitude_ok = 1'b0, halt = 1'b0, ref_byte_clock, serial_out, tx_ready;
  logic sync_enable = 1'b1;
  logic rx_comma_flag, rx_byte_clock_lead, rx_byte_clock_trail;
  logic input_present_flag, rx_bit_locked;
  logic [WORD_W-1:0] tx_word, rx_word, sh;
  int errors = 0, total_checks = 0;

  always #10ns sys_clk = ~sys_clk;

  gsba_mac_model u_gsba_mac_model (.tx_ready(tx_ready), .halt(halt),
    .ref_byte_clock(ref_byte_clock), .tx_word(tx_word));
  gsba_aligner #(.BIT_SYNC_P(12'h014)) u_gsba_aligner (.sys_clk(sys_clk), .rstn(rstn),
    .ref_byte_clock(ref_byte_clock), .tx_word(tx_word), .loopback_select(loopback_select),
    .sync_enable(sync_enable), .serial_in(serial_in), .amplitude_ok(amplitude_ok),
    .serial_out(serial_out), .tx_ready(tx_ready), .rx_word(rx_word),
    .rx_comma_flag(rx_comma_flag), .rx_byte_clock_lead(rx_byte_clock_lead),
    .rx_byte_clock_trail(rx_byte_clock_trail), .input_present_flag(input_present_flag),
    .rx_bit_locked(rx_bit_locked));

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic t_weak_input();
    amplitude_ok = 1'b0;
    cycles(6);
    check("weak word", RX_NO_SIGNAL, rx_word);
    check("weak flag", 10'h000, {9'h000, input_present_flag});
    amplitude_ok = 1'b1;
    cycles(6);
    check("valid flag", 10'h001, {9'h000, input_present_flag});
  endtask

  // Serial order: newest bit enters at the top, so sh[0] is the oldest
  task automatic t_tx_order();
    int n;
    u_gsba_mac_model.send(COMMA_WORD);
    u_gsba_mac_model.send(DATA_A);
    for (n = 0; n < 3000 && sh !== COMMA_WORD; n++) begin
      @(negedge sys_clk);
      sh = {serial_out, sh[WORD_W-1:1]};
    end
    check("tx first word", COMMA_WORD, sh);
    repeat (WORD_W) begin
      @(negedge sys_clk);
      sh = {serial_out, sh[WORD_W-1:1]};
    end
    check("tx next word", DATA_A, sh);
  endtask

  task automatic next_word(input logic [WORD_W-1:0] exp, input logic on_lead);
    logic pl, pt;
    int   n;
    pl = rx_byte_clock_lead;
    pt = rx_byte_clock_trail;
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk);
      if ((rx_byte_clock_lead && !pl) || (rx_byte_clock_trail && !pt)) break;
      pl = rx_byte_clock_lead;
      pt = rx_byte_clock_trail;
    end
    check("rx word", exp, rx_word);
    check("rx clock", {9'h000, on_lead}, {9'h000, rx_byte_clock_lead});
  endtask

  task automatic t_loopback_rx();
    int n;
    loopback_select = 1'b1;
    cycles(4);
    for (n = 0; n < 20; n++) begin
      @(negedge sys_clk);
      check("looped line", {9'h000, LOOP_PIN_LVL}, {9'h000, serial_out});
    end
    for (n = 0; n < 3000 && rx_bit_locked !== 1'b1; n++) @(negedge sys_clk);
    check("bit lock", 10'h001, {9'h000, rx_bit_locked});
    // Priming pair: its comma may be spent on realignment
    u_gsba_mac_model.send(COMMA_WORD);
    u_gsba_mac_model.send(DATA_B);
    u_gsba_mac_model.send(COMMA_WORD);
    u_gsba_mac_model.send(DATA_A);
    u_gsba_mac_model.send(COMMA_WORD);
    u_gsba_mac_model.send(DATA_B);
    for (n = 0; n < 3000 && rx_word !== DATA_B; n++) @(negedge sys_clk);
    check("priming word", DATA_B, rx_word);
    next_word(COMMA_WORD, 1'b1);
    check("comma flag", 10'h001, {9'h000, rx_comma_flag});
    next_word(DATA_A, 1'b0);
    next_word(COMMA_WORD, 1'b1);
    next_word(DATA_B, 1'b0);
  endtask

  // Sync off: a comma passes as plain data and the phase stays
  task automatic t_sync_off();
    int n;
    sync_enable = 1'b0;
    cycles(4);
    u_gsba_mac_model.send(COMMA_WORD);
    u_gsba_mac_model.send(DATA_A);
    for (n = 0; n < 3000 && rx_word !== COMMA_WORD; n++) @(negedge sys_clk);
    check("unsynced comma", COMMA_WORD, rx_word);
    check("unsynced flag", 10'h000, {9'h000, rx_comma_flag});
    cycles(10);
    check("kept phase", DATA_A, rx_word);
    sync_enable = 1'b1;
  endtask

  // Continuous reference outruns the serializer, so the buffer fills
  task automatic t_fill_drain();
    int n;
    for (n = 0; n < 2000 && tx_ready !== 1'b0; n++) @(negedge sys_clk);
    check("buffer full", 10'h000, {9'h000, tx_ready});
    loopback_select = 1'b0;
    halt = 1'b1;
    cycles(400);
    check("buffer drained", 10'h001, {9'h000, tx_ready});
    check("idle line", {9'h000, LINE_IDLE}, {9'h000, serial_out});
  endtask

  initial begin
    sh = '0;
    cycles(3);
    rstn = 1'b1;
    cycles(6);
    check("reset word", RX_NO_SIGNAL, rx_word);
    amplitude_ok = 1'b1;
    t_tx_order();
    t_loopback_rx();
    t_sync_off();
    t_weak_input();
    t_fill_drain();
    print_verdict();
  end

  initial begin
    #400us;
    errors++;
    print_verdict();
  end
endmodule // gsba_aligner_bench
